// ### design/rapi_pkg.sv
package rapi_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'he;
    localparam logic [3:0] REG_FLAG = 4'hf;

    localparam int CTRL_WEEKDAY_ALARM_ENABLE_BIT = 7;
    localparam int CTRL_DAILY_ALARM_ENABLE_BIT = 6;
    localparam int CTRL_SEL_LSB = 0;
    localparam int FLAG_DAILY_ALARM_FLAG_BIT = 0;
    localparam int FLAG_WEEKDAY_ALARM_FLAG_BIT = 1;
    localparam int FLAG_PERIODIC_FLAG_BIT = 2;

    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic EN_RESET = 1'b0;

    // ---------------------------------------------------------------
    // periodic select codes
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_OFF = 3'h0,
        SEL_FIXED_LOW = 3'h1,
        SEL_PULSE_2HZ = 3'h2,
        SEL_PULSE_1HZ = 3'h3,
        SEL_LVL_SEC = 3'h4,
        SEL_LVL_MIN = 3'h5,
        SEL_LVL_HOUR = 3'h6,
        SEL_LVL_MONTH = 3'h7
    } rapi_sel_t;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam longint CLK_HZ = 200_000_000;
    localparam longint SEC_CYC = CLK_HZ;
    localparam longint PULSE_LEAD_NS = 92_000;
    localparam longint PULSE_LEAD_CYC = (PULSE_LEAD_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
    localparam longint ADJ_MAX_NS = 3_784_000;
    localparam longint ADJ_MAX_CYC = (ADJ_MAX_NS * CLK_HZ) / 1_000_000_000;
    localparam logic [4:0] ADJ_PERIOD_SEC = 5'h14;
    localparam int CNT_W = 28;
    localparam int ADJ_W = 21;

    // ---------------------------------------------------------------
    // time values (bcd)
    // ---------------------------------------------------------------
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;

endpackage

// ### design/rapi_tick_if.sv
`timescale 1ns/1ps
interface rapi_tick_if;
    logic sec_write;
    logic signed [rapi_pkg::ADJ_W-1:0] adj_cyc;
    logic sec_inc;
    logic low_1hz;
    logic low_2hz;

    modport ctl (output sec_write, output adj_cyc, input sec_inc, input low_1hz, input low_2hz);
    modport div (input sec_write, input adj_cyc, output sec_inc, output low_1hz, output low_2hz);
endinterface

// ### design/rapi_divider.sv
`timescale 1ns/1ps
module rapi_divider #(
    parameter longint SEC_CYC = rapi_pkg::SEC_CYC,
    parameter longint LEAD_CYC = rapi_pkg::PULSE_LEAD_CYC
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    rapi_tick_if.div tick
);
    localparam logic [rapi_pkg::CNT_W-1:0] PER = rapi_pkg::CNT_W'(SEC_CYC);
    localparam logic [rapi_pkg::CNT_W-1:0] LEAD = rapi_pkg::CNT_W'(LEAD_CYC);

    typedef struct packed {
        logic [rapi_pkg::CNT_W-1:0] cnt;
        logic [rapi_pkg::CNT_W-1:0] len;
        logic [4:0] sec20;
        logic sec_inc;
        logic low_1hz;
        logic low_2hz;
    } rapi_div_t;

    rapi_div_t state_ff;
    rapi_div_t nxt_state;

    always_comb begin
        logic [rapi_pkg::CNT_W-1:0] half;
        logic [rapi_pkg::CNT_W-1:0] quarter;
        logic [rapi_pkg::CNT_W-1:0] pos;
        nxt_state = state_ff;
        nxt_state.sec_inc = 1'b0;
        if (tick.sec_write) begin
            // sub-second stages restart, so pulse output falls at once
            nxt_state.cnt = '0;
        end else if (state_ff.cnt >= state_ff.len - 1'b1) begin
            nxt_state.cnt = '0;
            nxt_state.sec_inc = 1'b1;
            if (state_ff.sec20 == rapi_pkg::ADJ_PERIOD_SEC - 1'b1) begin
                nxt_state.sec20 = '0;
            end else begin
                nxt_state.sec20 = state_ff.sec20 + 1'b1;
            end
            // one second in twenty is stretched or shrunk by the trim value
            if (nxt_state.sec20 == rapi_pkg::ADJ_PERIOD_SEC - 1'b1) begin
                nxt_state.len = PER + rapi_pkg::CNT_W'(tick.adj_cyc);
            end else begin
                nxt_state.len = PER;
            end
        end else begin
            nxt_state.cnt = state_ff.cnt + 1'b1;
        end
        half = nxt_state.len >> 1;
        quarter = half >> 1;
        pos = (nxt_state.cnt < half) ? nxt_state.cnt : nxt_state.cnt - half;
        // falling edge leads the second increment by the lead time
        nxt_state.low_1hz = (nxt_state.cnt >= nxt_state.len - LEAD) ||
                            (nxt_state.cnt < half - LEAD);
        nxt_state.low_2hz = (pos >= half - LEAD) || (pos < quarter - LEAD);
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= '0;
            state_ff.len <= PER;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign tick.sec_inc = state_ff.sec_inc;
    assign tick.low_1hz = state_ff.low_1hz;
    assign tick.low_2hz = state_ff.low_2hz;

endmodule // rapi_divider

// ### design/rapi_alarm.sv
`timescale 1ns/1ps
module rapi_alarm #(
    parameter bit USE_WDAY = 1'b1
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    input wire logic [6:0] alarm_wday_i,
    input wire logic [7:0] alarm_hour_i,
    input wire logic [7:0] alarm_min_i,
    input wire logic [2:0] wday_i,
    input wire logic [7:0] hour_i,
    input wire logic [7:0] min_i,
    output logic fire_o
);
    typedef struct packed {
        logic match;
        logic fire;
    } rapi_alarm_t;

    rapi_alarm_t state_ff;
    rapi_alarm_t nxt_state;

    always_comb begin
        logic day_ok;
        day_ok = !USE_WDAY || alarm_wday_i[wday_i];
        nxt_state.match = day_ok && (hour_i == alarm_hour_i) && (min_i == alarm_min_i);
        // only the rising edge of a match fires, so enabling during a standing
        // match waits for the next matching time
        nxt_state.fire = enable_i && nxt_state.match && !state_ff.match;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign fire_o = state_ff.fire;

endmodule // rapi_alarm

// ### design/rapi_irq.sv
`timescale 1ns/1ps
module rapi_irq #(
    parameter longint SEC_CYC = rapi_pkg::SEC_CYC,
    parameter longint LEAD_CYC = rapi_pkg::PULSE_LEAD_CYC,
    parameter longint ADJ_MAX_CYC = rapi_pkg::ADJ_MAX_CYC
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic power_on_flag_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic sec_write_i,
    input wire logic signed [rapi_pkg::ADJ_W-1:0] adj_cyc_i,
    input wire logic [7:0] sec_i,
    input wire logic [7:0] min_i,
    input wire logic [7:0] hour_i,
    input wire logic [2:0] wday_i,
    input wire logic [7:0] mday_i,
    input wire logic [6:0] alarm_w_wday_i,
    input wire logic [7:0] alarm_w_hour_i,
    input wire logic [7:0] alarm_w_min_i,
    input wire logic [7:0] alarm_d_hour_i,
    input wire logic [7:0] alarm_d_min_i,
    output logic sec_inc_o,
    output logic irq_out_n_o,
    output logic irq_oe_n_o
);
    localparam logic signed [rapi_pkg::ADJ_W-1:0] ADJ_LIM = rapi_pkg::ADJ_W'(ADJ_MAX_CYC);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic weekday_alarm_enable;
        logic daily_alarm_enable;
        logic [2:0] periodic_select;
        logic daily_alarm_flag;
        logic weekday_alarm_flag;
        logic periodic_flag;
        logic lvl_check;
        logic irq_n;
        logic [7:0] rdata;
    } rapi_top_t;

    rapi_top_t state_ff;
    rapi_top_t nxt_state;

    rapi_tick_if tick ();

    logic wk_fire;
    logic dy_fire;
    logic signed [rapi_pkg::ADJ_W-1:0] adj_clamped;

    // ---------------------------------------------------------------
    // sub-second divider and alarm comparators
    // ---------------------------------------------------------------
    // trim is clamped so a bad setting cannot exceed the documented swing
    always_comb begin
        if (adj_cyc_i > ADJ_LIM) begin
            adj_clamped = ADJ_LIM;
        end else if (adj_cyc_i < -ADJ_LIM) begin
            adj_clamped = -ADJ_LIM;
        end else begin
            adj_clamped = adj_cyc_i;
        end
    end

    assign tick.sec_write = sec_write_i;
    assign tick.adj_cyc = adj_clamped;

    rapi_divider #(
        .SEC_CYC(SEC_CYC),
        .LEAD_CYC(LEAD_CYC)
    ) u_div (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .tick(tick.div)
    );

    rapi_alarm #(
        .USE_WDAY(1'b1)
    ) u_alarm_wk (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .enable_i(state_ff.weekday_alarm_enable),
        .alarm_wday_i(alarm_w_wday_i),
        .alarm_hour_i(alarm_w_hour_i),
        .alarm_min_i(alarm_w_min_i),
        .wday_i(wday_i),
        .hour_i(hour_i),
        .min_i(min_i),
        .fire_o(wk_fire)
    );

    rapi_alarm #(
        .USE_WDAY(1'b0)
    ) u_alarm_dy (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .enable_i(state_ff.daily_alarm_enable),
        .alarm_wday_i(7'h00),
        .alarm_hour_i(alarm_d_hour_i),
        .alarm_min_i(alarm_d_min_i),
        .wday_i(wday_i),
        .hour_i(hour_i),
        .min_i(min_i),
        .fire_o(dy_fire)
    );

    // ---------------------------------------------------------------
    // registers, flags and output
    // ---------------------------------------------------------------
    always_comb begin
        logic lvl_event;
        logic wr_ctrl;
        logic wr_flag;
        logic per_low;
        logic clr_d;
        logic clr_w;
        logic clr_c;
        lvl_event = 1'b0;
        per_low = 1'b0;
        nxt_state = state_ff;
        wr_ctrl = reg_wr_i && (reg_addr_i == rapi_pkg::REG_CTRL);
        wr_flag = reg_wr_i && (reg_addr_i == rapi_pkg::REG_FLAG);
        // counters update on the increment; check their new values a cycle on
        nxt_state.lvl_check = tick.sec_inc;

        // level mode event selection
        case (rapi_pkg::rapi_sel_t'(state_ff.periodic_select))
            rapi_pkg::SEL_LVL_SEC: begin
                lvl_event = state_ff.lvl_check;
            end
            rapi_pkg::SEL_LVL_MIN: begin
                lvl_event = state_ff.lvl_check && (sec_i == rapi_pkg::BCD_ZERO);
            end
            rapi_pkg::SEL_LVL_HOUR: begin
                lvl_event = state_ff.lvl_check && (sec_i == rapi_pkg::BCD_ZERO) &&
                            (min_i == rapi_pkg::BCD_ZERO);
            end
            rapi_pkg::SEL_LVL_MONTH: begin
                lvl_event = state_ff.lvl_check && (sec_i == rapi_pkg::BCD_ZERO) &&
                            (min_i == rapi_pkg::BCD_ZERO) &&
                            (hour_i == rapi_pkg::BCD_ZERO) &&
                            (mday_i == rapi_pkg::BCD_ONE);
            end
            default: begin
                lvl_event = 1'b0;
            end
        endcase

        // control register
        if (wr_ctrl) begin
            nxt_state.weekday_alarm_enable = reg_wdata_i[rapi_pkg::CTRL_WEEKDAY_ALARM_ENABLE_BIT];
            nxt_state.daily_alarm_enable = reg_wdata_i[rapi_pkg::CTRL_DAILY_ALARM_ENABLE_BIT];
            nxt_state.periodic_select = reg_wdata_i[rapi_pkg::CTRL_SEL_LSB +: 3];
        end

        // flags: writing 1 leaves a flag alone, an event in the same cycle wins
        clr_d = wr_flag && !reg_wdata_i[rapi_pkg::FLAG_DAILY_ALARM_FLAG_BIT];
        clr_w = wr_flag && !reg_wdata_i[rapi_pkg::FLAG_WEEKDAY_ALARM_FLAG_BIT];
        clr_c = wr_flag && !reg_wdata_i[rapi_pkg::FLAG_PERIODIC_FLAG_BIT];
        nxt_state.daily_alarm_flag = (state_ff.daily_alarm_flag && !clr_d) || dy_fire;
        nxt_state.weekday_alarm_flag = (state_ff.weekday_alarm_flag && !clr_w) ||
                                       wk_fire;
        nxt_state.periodic_flag = (state_ff.periodic_flag && !clr_c) || lvl_event;

        // power-on flag overrides control writes and flag events
        if (power_on_flag_i) begin
            nxt_state.weekday_alarm_enable = rapi_pkg::EN_RESET;
            nxt_state.daily_alarm_enable = rapi_pkg::EN_RESET;
            nxt_state.periodic_select = rapi_pkg::SEL_RESET;
            nxt_state.daily_alarm_flag = rapi_pkg::FLAG_RESET;
            nxt_state.weekday_alarm_flag = rapi_pkg::FLAG_RESET;
            nxt_state.periodic_flag = rapi_pkg::FLAG_RESET;
        end

        // periodic drive, from the already registered select
        case (rapi_pkg::rapi_sel_t'(state_ff.periodic_select))
            rapi_pkg::SEL_OFF: begin
                per_low = 1'b0;
            end
            rapi_pkg::SEL_FIXED_LOW: begin
                per_low = 1'b1;
            end
            rapi_pkg::SEL_PULSE_2HZ: begin
                per_low = tick.low_2hz;
            end
            rapi_pkg::SEL_PULSE_1HZ: begin
                per_low = tick.low_1hz;
            end
            default: begin
                per_low = state_ff.periodic_flag;
            end
        endcase

        // negative-logic or of all sources
        nxt_state.irq_n = !((state_ff.daily_alarm_flag && state_ff.daily_alarm_enable) ||
                            (state_ff.weekday_alarm_flag && state_ff.weekday_alarm_enable) ||
                            per_low);

        // read data, unused bits read as zero
        if (reg_rd_i) begin
            nxt_state.rdata = 8'h00;
            if (reg_addr_i == rapi_pkg::REG_CTRL) begin
                nxt_state.rdata[rapi_pkg::CTRL_WEEKDAY_ALARM_ENABLE_BIT] = state_ff.weekday_alarm_enable;
                nxt_state.rdata[rapi_pkg::CTRL_DAILY_ALARM_ENABLE_BIT] = state_ff.daily_alarm_enable;
                nxt_state.rdata[rapi_pkg::CTRL_SEL_LSB +: 3] = state_ff.periodic_select;
            end else if (reg_addr_i == rapi_pkg::REG_FLAG) begin
                nxt_state.rdata[rapi_pkg::FLAG_DAILY_ALARM_FLAG_BIT] = state_ff.daily_alarm_flag;
                nxt_state.rdata[rapi_pkg::FLAG_WEEKDAY_ALARM_FLAG_BIT] = state_ff.weekday_alarm_flag;
                nxt_state.rdata[rapi_pkg::FLAG_PERIODIC_FLAG_BIT] = state_ff.periodic_flag;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= '0;
            state_ff.irq_n <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // open-drain pin: data and enable both carry the registered interrupt level
    assign reg_rdata_o = state_ff.rdata;
    assign sec_inc_o = tick.sec_inc;
    assign irq_out_n_o = state_ff.irq_n;
    assign irq_oe_n_o = state_ff.irq_n;

endmodule // rapi_irq

// ### verif/rapi_irq_props.sv
`timescale 1ns/1ps
module rapi_props #(
    parameter longint SEC_CYC = 1000,
    parameter longint LEAD_CYC = 40,
    parameter longint ADJ_MAX_CYC = 50
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic power_on_flag_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic sec_write_i,
    input wire logic signed [rapi_pkg::ADJ_W-1:0] adj_cyc_i,
    input wire logic sec_inc_o,
    input wire logic irq_out_n_o,
    input wire logic irq_oe_n_o
);
    localparam int LO = int'(LEAD_CYC) - 2;
    localparam int HI = int'(LEAD_CYC) + 3;
    // ------
    // shadow of the control byte, rebuilt from bus writes and the power-on flag
    // ------
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [3:0] age_ff;
    logic [3:0] wr_age_ff;
    longint cnt_ff;
    logic [4:0] sec20_ff;
    longint trim;
    // clamped trim that the twentieth second should carry
    assign trim = (adj_cyc_i > ADJ_MAX_CYC) ? ADJ_MAX_CYC :
        (adj_cyc_i < -ADJ_MAX_CYC) ? -ADJ_MAX_CYC : longint'(adj_cyc_i);
    assign nxt_ctrl = power_on_flag_i ? 8'h00 :
        (reg_wr_i && reg_addr_i == 4'he) ? reg_wdata_i : ctrl_ff;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_ff <= 8'h00;
            age_ff <= 4'h0;
            wr_age_ff <= 4'h0;
            cnt_ff <= 0;
            sec20_ff <= 5'h00;
        end else begin
            sec20_ff <= !sec_inc_o ? sec20_ff : (sec20_ff == 5'h13) ? 5'h00 : sec20_ff + 5'h01;
            ctrl_ff <= nxt_ctrl;
            age_ff <= (nxt_ctrl != ctrl_ff) ? 4'h0 : age_ff + {3'h0, age_ff != 4'hf};
            wr_age_ff <= sec_write_i ? 4'h0 : wr_age_ff + {3'h0, wr_age_ff != 4'hf};
            cnt_ff <= (sec_inc_o || sec_write_i) ? 0 : cnt_ff + 1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // settle time after a mode change keeps in-flight edges out of the checks
    sequence s_lvl_tick;
        sec_inc_o && ctrl_ff == 8'h04 && age_ff == 4'hf;
    endsequence
    sequence s_pulse_fall;
        $fell(irq_out_n_o) && ctrl_ff == 8'h03 && age_ff == 4'hf && wr_age_ff == 4'hf;
    endsequence
    AST_OE_FOLLOWS: assert property (irq_oe_n_o == irq_out_n_o)
        else $error("pin enable differs from interrupt level");
    AST_UNMAPPED_RD: assert property (
        reg_rd_i && reg_addr_i < 4'he |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_CTRL_RB: assert property (
        reg_rd_i && !reg_wr_i && !power_on_flag_i && reg_addr_i == 4'he
        |=> reg_rdata_o == (ctrl_ff & 8'hc7))
        else $error("control readback mismatch");
    AST_IDLE_HIGH: assert property (
        ctrl_ff[7:6] == 2'h0 && ctrl_ff[2:0] == 3'h0 && age_ff > 4'h2 |-> irq_out_n_o)
        else $error("output low with all sources off");
    AST_FIXED_LOW: assert property (ctrl_ff[2:0] == 3'h1 && age_ff > 4'h2 |-> !irq_out_n_o)
        else $error("fixed low select not low");
    AST_LVL_FALL: assert property (s_lvl_tick |-> ##[2:4] !irq_out_n_o)
        else $error("level event missing after second increment");
    AST_PULSE_LEAD: assert property (s_pulse_fall |-> ##[LO:HI] sec_inc_o)
        else $error("second increment not after pulse fall");
    AST_INC_PULSE: assert property (sec_inc_o |=> !sec_inc_o)
        else $error("second increment longer than one cycle");
    AST_INC_PERIOD: assert property (
        sec_inc_o && sec20_ff != 5'h13 |-> cnt_ff >= SEC_CYC - 3 && cnt_ff <= SEC_CYC + 1)
        else $error("second period wrong");
    AST_TRIM_PERIOD: assert property (
        sec_inc_o && sec20_ff == 5'h13 |-> cnt_ff >= SEC_CYC + trim - 3 &&
        cnt_ff <= SEC_CYC + trim + 1)
        else $error("trimmed second period wrong");
endmodule // rapi_props

bind rapi_irq rapi_props #(.SEC_CYC(SEC_CYC), .LEAD_CYC(LEAD_CYC),
    .ADJ_MAX_CYC(ADJ_MAX_CYC)) u_props (
    .clk_i, .reset_n_i, .power_on_flag_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .sec_write_i, .adj_cyc_i, .sec_inc_o, .irq_out_n_o,
    .irq_oe_n_o);

// ### verif/rapi_host.sv
`timescale 1ns/1ps
module rapi_host (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic wr_o,
    output logic rd_o,
    output logic [3:0] addr_o,
    output logic [7:0] wdata_o
);
    // ------
    // host side of the register port
    // ------
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 4'h0;
        wdata_o = 8'h00;
    end
    // idle lines are inverted so a stale value is never mistaken for a live one
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    task automatic get(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
    endtask
endmodule // rapi_host

// ### verif/rapi_irq_tb.sv
`timescale 1ns/1ps
module rapi_irq_tb;
    localparam longint SEC = 1000;
    localparam longint ADJ = 50;
    logic clk_i, reset_n_i, power_on_flag_i, reg_wr_i, reg_rd_i, sec_write_i;
    logic [3:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, sec_i, min_i, hour_i, mday_i;
    logic [7:0] alarm_w_hour_i, alarm_w_min_i, alarm_d_hour_i, alarm_d_min_i;
    logic signed [rapi_pkg::ADJ_W-1:0] adj_cyc_i;
    logic [2:0] wday_i;
    logic [6:0] alarm_w_wday_i;
    logic sec_inc_o, irq_out_n_o, irq_oe_n_o, prev;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int lows, falls;
    int span = 0;
    // rows: address, write data, expected readback
    logic [19:0] rows [6] = '{20'he_ffc7, 20'hf_ff00, 20'h3_ff00, 20'he_4141,
        20'he_0000, 20'h0_aa00};
    rapi_irq #(.SEC_CYC(SEC), .LEAD_CYC(40), .ADJ_MAX_CYC(ADJ)) uut (.clk_i, .reset_n_i,
        .power_on_flag_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
        .sec_write_i, .adj_cyc_i, .sec_i, .min_i, .hour_i, .wday_i, .mday_i,
        .alarm_w_wday_i, .alarm_w_hour_i, .alarm_w_min_i, .alarm_d_hour_i,
        .alarm_d_min_i, .sec_inc_o, .irq_out_n_o, .irq_oe_n_o);
    rapi_host host (.clk_i, .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
        .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.get(a, d);
        chk8(d, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wait_inc;
        int i;
        for (i = 0; i < 2 * SEC && sec_inc_o !== 1'b1; i++) begin
            tick(1);
        end
        if (i == 2 * SEC) begin
            fail_count++;
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // ceiling is about twice the expected run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 70000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        reset_n_i = 1'b0;
        power_on_flag_i = 1'b0;
        sec_write_i = 1'b0;
        adj_cyc_i = '0;
        {sec_i, min_i, hour_i, mday_i} = 32'h0529_0802;
        {alarm_w_hour_i, alarm_w_min_i, alarm_d_hour_i, alarm_d_min_i} = 32'h0830_0830;
        wday_i = 3'h2;
        alarm_w_wday_i = 7'h08;
        repeat (5) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        chk1(irq_out_n_o, 1'b1);
        for (int i = 0; i < 6; i++) begin
            host.put(rows[i][19:16], rows[i][15:8]);
            rdchk(rows[i][19:16], rows[i][7:0]);
        end
        host.put(4'he, 8'hc0);
        min_i = 8'h30;
        tick(4);
        chk1(irq_out_n_o, 1'b0);
        rdchk(4'hf, 8'h01);
        host.put(4'hf, 8'h00);
        tick(2);
        chk1(irq_out_n_o, 1'b1);
        rdchk(4'he, 8'hc0);
        min_i = 8'h31;
        tick(3);
        min_i = 8'h30;
        tick(4);
        chk1(irq_out_n_o, 1'b0);
        host.put(4'hf, 8'h00);
        host.put(4'he, 8'h00);
        host.put(4'he, 8'hc0);
        tick(8);
        chk1(irq_out_n_o, 1'b1);
        wday_i = 3'h3;
        min_i = 8'h31;
        tick(3);
        min_i = 8'h30;
        tick(4);
        rdchk(4'hf, 8'h03);
        host.put(4'hf, 8'h01);
        tick(2);
        rdchk(4'hf, 8'h01);
        chk1(irq_out_n_o, 1'b0);
        host.put(4'he, 8'h00);
        tick(2);
        chk1(irq_out_n_o, 1'b1);
        host.put(4'hf, 8'h00);
        min_i = 8'h31;
        host.put(4'he, 8'h01);
        tick(2);
        chk1(irq_out_n_o, 1'b0);
        for (int c = 4; c < 8; c++) begin
            {sec_i, min_i, hour_i, mday_i} = 32'h0501_0102;
            host.put(4'hf, 8'h00);
            host.put(4'he, {5'h00, c[2:0]});
            wait_inc();
            tick(4);
            rdchk(4'hf, (c == 4) ? 8'h04 : 8'h00);
            {sec_i, min_i, hour_i, mday_i} = 32'h0000_0001;
            wait_inc();
            tick(4);
            chk1(irq_out_n_o, 1'b0);
            rdchk(4'hf, 8'h04);
        end
        host.put(4'hf, 8'h00);
        tick(2);
        chk1(irq_out_n_o, 1'b1);
        host.put(4'he, 8'h03);
        sec_write_i = 1'b1;
        tick(1);
        sec_write_i = 1'b0;
        tick(2);
        chk1(irq_out_n_o, 1'b0);
        for (int c = 2; c < 4; c++) begin
            host.put(4'he, {6'h00, c[1:0]});
            wait_inc();
            lows = 0;
            falls = 0;
            for (int k = 0; k < SEC; k++) begin
                prev = irq_out_n_o;
                tick(1);
                lows += int'(!irq_out_n_o);
                falls += int'(prev && !irq_out_n_o);
            end
            chk8(8'(falls), (c == 2) ? 8'h02 : 8'h01);
            chk1(lows > 495 && lows < 505, 1'b1);
        end
        // an over-range trim is clamped and lands on one second in twenty
        adj_cyc_i = 21'sh0_0050;
        wait_inc();
        falls = 0;
        for (int s = 0; s < 20; s++) begin
            lows = 0;
            do begin
                tick(1);
                lows++;
            end while (sec_inc_o !== 1'b1 && lows < 2 * SEC);
            if (lows != SEC) begin
                falls++;
                span = lows;
            end
        end
        chk8(8'(falls), 8'h01);
        chk1(span == SEC + ADJ, 1'b1);
        host.put(4'he, 8'hc7);
        power_on_flag_i = 1'b1;
        tick(1);
        power_on_flag_i = 1'b0;
        tick(2);
        rdchk(4'he, 8'h00);
        rdchk(4'hf, 8'h00);
        chk1(irq_out_n_o, 1'b1);
        print_verdict();
    end
endmodule // rapi_irq_tb
